//--- iobf_consts.svh
// Constants for the I/O block and interrupt forwarding enable registers.
`ifndef IOBF_CONSTS_SVH
`define IOBF_CONSTS_SVH

// ****************************************************************
// Register indices; the byte address of each is four times the index.
// ****************************************************************
`define IOBF_IDX_W 10
`define IOBF_IDX_BLK_LO 10'h1D4
`define IOBF_IDX_BLK_HI 10'h1D5
`define IOBF_IDX_IRQ 10'h1DE

// ****************************************************************
// Field widths and reset values.
// ****************************************************************
`define IOBF_BLK_LO_W 8
`define IOBF_BLK_HI_W 4
`define IOBF_IRQ_W 8
`define IOBF_BLK_N 12
`define IOBF_RST_BLK_LO 8'h01
`define IOBF_RST_BLK_HI 4'h0
`define IOBF_RST_IRQ 8'h00
`define IOBF_EN_OFF 1'b0
`define IOBF_EN_ON 1'b1

// ****************************************************************
// Inclusive I/O port ranges, one pair per enable bit.
// ****************************************************************
`define IOBF_B0_LO 16'h0080
`define IOBF_B0_HI 16'h0080
`define IOBF_B1_LO 16'h0100
`define IOBF_B1_HI 16'h01CF
`define IOBF_B2_LO 16'h0200
`define IOBF_B2_HI 16'h02E7
`define IOBF_B3_LO 16'h02E8
`define IOBF_B3_HI 16'h02EF
`define IOBF_B4_LO 16'h02F0
`define IOBF_B4_HI 16'h02F7
`define IOBF_B5_LO 16'h02F8
`define IOBF_B5_HI 16'h02FF
`define IOBF_B6_LO 16'h0300
`define IOBF_B6_HI 16'h0377
`define IOBF_B7_LO 16'h0378
`define IOBF_B7_HI 16'h03E7
`define IOBF_B8_LO 16'h03E8
`define IOBF_B8_HI 16'h03EF
`define IOBF_B9_LO 16'h03F0
`define IOBF_B9_HI 16'h03F7
`define IOBF_B10_LO 16'h03F8
`define IOBF_B10_HI 16'h03FF
`define IOBF_B11_LO 16'h0400
`define IOBF_B11_HI 16'h0AFF

`endif

//--- iobf_pkg.sv
// Types shared by the forwarding enable block.
package iobf_pkg;

  // ****************************************************************
  // I/O cycle lookup request and decision.
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic claimed;
    logic [15:0] addr;
  } iobf_io_req_t;

  typedef struct packed {
    logic valid;
    logic forward;
    logic [15:0] addr;
  } iobf_io_dec_t;

endpackage

//--- iobf_top.sv
// Forwarding enable registers and decisions for the expansion bus bridge.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "iobf_consts.svh"

// Overview of operation
// [R1] Each I/O port block has an enable; set means cycles cross both ways.
// [R2] Every enable bit: zero disables forwarding, one enables it.
// [R3] Low register bit 7 gates ports 0x378 to 0x3E7.
// [R4] Low register bit 6 gates ports 0x300 to 0x377.
// [R5] Low register bit 5 gates ports 0x2F8 to 0x2FF.
// [R6] Low register bit 4 gates ports 0x2F0 to 0x2F7.
// [R7] Low register bit 3 gates ports 0x2E8 to 0x2EF.
// [R8] Low register bit 2 gates ports 0x200 to 0x2E7.
// [R9] Low register bit 1 gates ports 0x100 to 0x1CF.
// [R10] Low register bit 0 gates the single port 0x080.
// [R11] The port 0x080 enable is set after reset.
// [R12] High register bit 3 gates ports 0x400 to 0xAFF.
// [R13] High register bit 2 gates ports 0x3F8 to 0x3FF.
// [R14] High register bit 1 gates ports 0x3F0 to 0x3F7.
// [R15] High register bit 0 gates ports 0x3E8 to 0x3EF.
// [R16] High register bits 7 to 4 are reserved and do nothing.
// [R17] Ports claimed by on-board devices are not forwarded.
// [R18] Each legacy interrupt has an enable gating it onto serial IRQ.
// [R19] Interrupt enable bits 7..0 map to lines 11,10,9,7,6,5,4,3.
// [R20] All enable registers stay readable and writable at run time.
// [R21] Software checks an interrupt is unassigned before enabling it.
// [R22] A cleared enable forwards no cycle and propagates no interrupt.

module iobf_top #(
  parameter int APB_AW = 12,
  parameter int IRQ_N = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire iobf_pkg::iobf_io_req_t io_req,
  output iobf_pkg::iobf_io_dec_t io_dec,
  input wire logic [IRQ_N-1:0] exp_irq,
  output logic [IRQ_N-1:0] serirq_irq
);

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************

  // The register indices need ten address bits above the byte lane.
  if (APB_AW < `IOBF_IDX_W + 2) begin : g_aw_chk
    $error("APB_AW too small for the register map");
  end

  // The interrupt register holds exactly one bit per forwarded line.
  if (IRQ_N != `IOBF_IRQ_W) begin : g_irq_chk
    $error("IRQ_N must equal the interrupt register width");
  end

  // ****************************************************************
  // Functions.
  // ****************************************************************

  // Inclusive range test used for every port block.
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Hit vector in enable order: bits 7..0 low register, 11..8 high.
  function automatic logic [`IOBF_BLK_N-1:0] block_hits(
      input logic [15:0] a);
    logic [`IOBF_BLK_N-1:0] h;
    h = '0;
    h[0] = in_range(a, `IOBF_B0_LO, `IOBF_B0_HI); // [R10]
    h[1] = in_range(a, `IOBF_B1_LO, `IOBF_B1_HI); // [R9]
    h[2] = in_range(a, `IOBF_B2_LO, `IOBF_B2_HI); // [R8]
    h[3] = in_range(a, `IOBF_B3_LO, `IOBF_B3_HI); // [R7]
    h[4] = in_range(a, `IOBF_B4_LO, `IOBF_B4_HI); // [R6]
    h[5] = in_range(a, `IOBF_B5_LO, `IOBF_B5_HI); // [R5]
    h[6] = in_range(a, `IOBF_B6_LO, `IOBF_B6_HI); // [R4]
    h[7] = in_range(a, `IOBF_B7_LO, `IOBF_B7_HI); // [R3]
    h[8] = in_range(a, `IOBF_B8_LO, `IOBF_B8_HI); // [R15]
    h[9] = in_range(a, `IOBF_B9_LO, `IOBF_B9_HI); // [R14]
    h[10] = in_range(a, `IOBF_B10_LO, `IOBF_B10_HI); // [R13]
    h[11] = in_range(a, `IOBF_B11_LO, `IOBF_B11_HI); // [R12]
    block_hits = h;
  endfunction

  // Word index decode of the APB byte address.
  function automatic logic idx_is(input logic [APB_AW-1:0] a,
                                  input logic [`IOBF_IDX_W-1:0] idx);
    idx_is = (a[`IOBF_IDX_W+1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // ****************************************************************
  // Registers.
  // ****************************************************************

  logic [`IOBF_BLK_LO_W-1:0] blk_lo_r;
  logic [`IOBF_BLK_HI_W-1:0] blk_hi_r;
  logic [`IOBF_IRQ_W-1:0] irq_en_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  iobf_pkg::iobf_io_dec_t io_dec_r;
  iobf_pkg::iobf_io_dec_t io_dec_nxt;
  logic [IRQ_N-1:0] irq_meta_r;
  logic [IRQ_N-1:0] irq_sync_r;
  logic [IRQ_N-1:0] serirq_irq_r;

  logic sel_lo;
  logic sel_hi;
  logic sel_irq;
  logic mapped;
  logic setup_ph;
  logic wr_done;
  logic [`IOBF_BLK_N-1:0] blk_en;
  logic [`IOBF_BLK_N-1:0] req_hits;
  logic [31:0] rd_mux;

  // ****************************************************************
  // APB decode.
  // ****************************************************************

  // Address, direction and data are held by the master all transfer.
  assign sel_lo = idx_is(paddr, `IOBF_IDX_BLK_LO);
  assign sel_hi = idx_is(paddr, `IOBF_IDX_BLK_HI);
  assign sel_irq = idx_is(paddr, `IOBF_IDX_IRQ);
  assign mapped = sel_lo | sel_hi | sel_irq;
  assign setup_ph = psel & ~penable;
  // A write lands only at the edge where the access completes.
  assign wr_done = psel & penable & pready_r & pwrite & mapped;

  // Read mux; unused and reserved bits read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_lo) begin
      rd_mux[`IOBF_BLK_LO_W-1:0] = blk_lo_r; // [R20]
    end
    if (sel_hi) begin
      rd_mux[`IOBF_BLK_HI_W-1:0] = blk_hi_r; // [R16]
    end
    if (sel_irq) begin
      rd_mux[`IOBF_IRQ_W-1:0] = irq_en_r; // [R20]
    end
  end

  // Every access takes exactly one wait-free access cycle; pready is
  // raised at the edge ending setup so it can come from a flip-flop.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
    end
  end

  // Read data and error are prepared alongside pready.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~mapped;
    end else begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Enable registers.
  // ****************************************************************

  // Block enables; only port 0x080 is forwarded out of reset.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_lo_r <= `IOBF_RST_BLK_LO; // [R11]
    end else if (wr_done && sel_lo) begin
      blk_lo_r <= pwdata[`IOBF_BLK_LO_W-1:0]; // [R20]
    end
  end

  // Upper four bits are not stored, so writes to them are lost.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_hi_r <= `IOBF_RST_BLK_HI;
    end else if (wr_done && sel_hi) begin
      blk_hi_r <= pwdata[`IOBF_BLK_HI_W-1:0]; // [R16]
    end
  end

  // Interrupt enables; the bridge cannot tell whether a line is already
  // owned elsewhere, so that check is left to software.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_r <= `IOBF_RST_IRQ;
    end else if (wr_done && sel_irq) begin
      irq_en_r <= pwdata[`IOBF_IRQ_W-1:0]; // [R20] [R21]
    end
  end

  // ****************************************************************
  // I/O cycle forwarding decision.
  // ****************************************************************

  // One enable per block, same order as the hit vector.
  assign blk_en = {blk_hi_r, blk_lo_r}; // [R1]
  assign req_hits = block_hits(io_req.addr);

  // An enable of one lets the block through, zero blocks it.
  always_comb begin
    io_dec_nxt.valid = io_req.valid;
    io_dec_nxt.addr = io_req.addr;
    io_dec_nxt.forward = 1'b0;
    if (io_req.valid && !io_req.claimed) begin // [R17]
      io_dec_nxt.forward = |(req_hits & blk_en); // [R1] [R2] [R22]
    end
  end

  // Decision is registered; it follows the request by one cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_dec_r <= '0;
    end else begin
      io_dec_r <= io_dec_nxt;
    end
  end

  // ****************************************************************
  // Interrupt forwarding.
  // ****************************************************************

  // Expansion bus lines are asynchronous; two stages before use.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_meta_r <= '0;
      irq_sync_r <= '0;
    end else begin
      irq_meta_r <= exp_irq;
      irq_sync_r <= irq_meta_r;
    end
  end

  // Bit n of the enable gates input n; order is 11,10,9,7,6,5,4,3.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serirq_irq_r <= '0;
    end else begin
      serirq_irq_r <= irq_sync_r & irq_en_r; // [R18] [R19] [R22]
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign io_dec = io_dec_r;
  assign serirq_irq = serirq_irq_r;

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Helper: enabled blocks hit by the current lookup address.
  logic [`IOBF_BLK_N-1:0] chk_en_hits;
  assign chk_en_hits = block_hits(io_req.addr) & blk_en;

  // Unclaimed port 0x080 forwarded whenever its enable is one.
  port80_fwd_a: assert property ( // [R10]
    io_req.valid && !io_req.claimed && io_req.addr == `IOBF_B0_LO &&
    blk_lo_r[0] |=> io_dec_r.forward)
    else $error("port 0x080 not forwarded while enabled");

  // Claimed ports are never forwarded.
  claimed_block_a: assert property ( // [R17]
    io_req.valid && io_req.claimed |=> !io_dec_r.forward)
    else $error("claimed port was forwarded");

  // No enabled block hit means no forward.
  disabled_block_a: assert property ( // [R22]
    io_req.valid && chk_en_hits == '0 |=> !io_dec_r.forward)
    else $error("port forwarded with its block disabled");

  // A forward always traces back to a set enable and a hit.
  fwd_cause_a: assert property ( // [R2]
    io_dec_r.forward |-> $past(io_req.valid) && !$past(io_req.claimed) &&
    $past(chk_en_hits) != '0)
    else $error("forward without enabled block");

  // Top of the 0x3E8 block with its enable set.
  range_3e8_a: assert property ( // [R15]
    io_req.valid && !io_req.claimed && io_req.addr == `IOBF_B8_HI &&
    blk_hi_r[0] |=> io_dec_r.forward)
    else $error("port 0x3EF not forwarded while enabled");

  // Interrupt path: pin to output in three edges, gated by enable.
  irq_path_a: assert property ( // [R18]
    !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |->
    serirq_irq_r == ($past(exp_irq, 3) & $past(irq_en_r)))
    else $error("interrupt output does not follow gated input");

  // Disabled interrupt lines stay quiet.
  irq_masked_a: assert property ( // [R22]
    (serirq_irq_r & ~$past(irq_en_r)) == '0)
    else $error("disabled interrupt line propagated");

  // Each setup phase is answered in the next cycle.
  apb_answer_a: assert property ( // [R20]
    psel && !penable |=> pready_r ##1 !pready_r)
    else $error("APB answer not after one cycle");

  // A completed write to the low register is stored.
  write_low_a: assert property ( // [R20]
    wr_done && sel_lo |=> blk_lo_r == $past(pwdata[`IOBF_BLK_LO_W-1:0]))
    else $error("low block enable write not stored");

  // A completed write to the high register stores only its low four bits.
  reserved_hi_a: assert property ( // [R16]
    wr_done && sel_hi |=> blk_hi_r == $past(pwdata[`IOBF_BLK_HI_W-1:0]))
    else $error("high block enable write mishandled");

  // Reads of the high register never show bits above bit 3.
  reserved_rd_a: assert property ( // [R16]
    setup_ph && sel_hi && !pwrite |=> prdata_r[31:4] == 28'h0000000 &&
    prdata_r[3:0] == $past(blk_hi_r))
    else $error("reserved bits read nonzero");

  // Unmapped accesses report an error.
  unmapped_err_a: assert property ( // [R20]
    setup_ph && !mapped |=> pslverr_r && pready_r)
    else $error("unmapped access not flagged");

  // A completed write to the interrupt register is stored.
  write_irq_a: assert property ( // [R20]
    wr_done && sel_irq |=> irq_en_r == $past(pwdata[`IOBF_IRQ_W-1:0]))
    else $error("interrupt enable write not stored");

  // Reads of the low register return its stored bits.
  read_low_a: assert property ( // [R20]
    setup_ph && sel_lo && !pwrite |=>
    prdata_r == {24'h00_0000, $past(blk_lo_r)})
    else $error("low block enable read mismatch");

  // Refused writes leave every enable untouched.
  refused_wr_a: assert property ( // [R20]
    psel && penable && pwrite && !mapped |=> $stable(blk_lo_r) &&
    $stable(blk_hi_r) && $stable(irq_en_r))
    else $error("unmapped write changed an enable");

  // Outside the access cycle the bus outputs rest at zero.
  bus_idle_a: assert property ( // [R20]
    !pready_r |-> prdata_r == 32'h0000_0000 && !pslverr_r)
    else $error("read data or error outside access cycle");

  // ****************************************************************
  // Cover points.
  // ****************************************************************

  fwd_seen_c: cover property (io_dec_r.forward);
  irq_seen_c: cover property (serirq_irq_r != '0);
  wr_irq_c: cover property (wr_done && sel_irq);
  claimed_c: cover property (io_req.valid && io_req.claimed &&
                             chk_en_hits != '0);
  err_seen_c: cover property (pready_r && pslverr_r);

endmodule

//--- iobf_card_model.sv
// Model of the expansion bus cards that raise legacy interrupt lines.
`timescale 1ns/100ps

module iobf_card_model (
  input wire logic [7:0] card_req,
  output wire logic [7:0] exp_irq
);
  // Cards switch their lines with no relation to ref_clk.
  // The skew makes the bridge synchroniser see unaligned edges.
  assign #1.3 exp_irq = card_req;
endmodule

//--- iobf_top_tb.sv
// Self-checking bench for the forwarding enable block.
`timescale 1ns/100ps
`include "iobf_consts.svh"

module iobf_top_tb;
  // ****************************************************************
  // Signals, expected state and range tables.
  // ****************************************************************
  localparam logic [11:0] A_LO = {`IOBF_IDX_BLK_LO, 2'b00};
  localparam logic [11:0] A_HI = {`IOBF_IDX_BLK_HI, 2'b00};
  localparam logic [11:0] A_IRQ = {`IOBF_IDX_IRQ, 2'b00};
  localparam logic [15:0] LO_T [12] = '{`IOBF_B0_LO, `IOBF_B1_LO,
    `IOBF_B2_LO, `IOBF_B3_LO, `IOBF_B4_LO, `IOBF_B5_LO, `IOBF_B6_LO,
    `IOBF_B7_LO, `IOBF_B8_LO, `IOBF_B9_LO, `IOBF_B10_LO, `IOBF_B11_LO};
  localparam logic [15:0] HI_T [12] = '{`IOBF_B0_HI, `IOBF_B1_HI,
    `IOBF_B2_HI, `IOBF_B3_HI, `IOBF_B4_HI, `IOBF_B5_HI, `IOBF_B6_HI,
    `IOBF_B7_HI, `IOBF_B8_HI, `IOBF_B9_HI, `IOBF_B10_HI, `IOBF_B11_HI};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  iobf_pkg::iobf_io_req_t io_req = '0;
  iobf_pkg::iobf_io_dec_t io_dec;
  logic [7:0] card_req = 8'h00;
  logic [7:0] exp_irq;
  logic [7:0] serirq_irq;
  logic [11:0] en_blk = 12'h001;
  logic [7:0] en_irq = 8'h00;
  logic [33:0] qa[$];
  logic [16:0] qd[$];
  logic [33:0] ea;
  logic [16:0] ed;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;

  iobf_top iobf_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_req(io_req),
    .io_dec(io_dec), .exp_irq(exp_irq), .serirq_irq(serirq_irq));
  iobf_card_model iobf_card_model_i (.card_req(card_req), .exp_irq(exp_irq));

  always #2 ref_clk = ~ref_clk;

  // ****************************************************************
  // Tasks and expectation helpers.
  // ****************************************************************
  // Forward only when not claimed and inside an enabled block.
  function automatic logic exp_fwd(logic [15:0] a, logic c);
    logic f;
    f = 1'b0;
    for (int k = 0; k < 12; k++) begin
      if (a >= LO_T[k] && a <= HI_T[k] && en_blk[k]) f = 1'b1;
    end
    return f & ~c;
  endfunction

  task automatic conclude();
    $display("TB: counts tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Expected note is {is_read, slverr, data}; an edge passes after release.
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
                     logic [33:0] e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    qa.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic look(logic [15:0] a, logic c);
    io_req <= '{valid: 1'b1, claimed: c, addr: a};
    qd.push_back({exp_fwd(a, c), a});
    @(posedge ref_clk);
  endtask

  // Random junk in reserved bits must neither stick nor read back.
  task automatic set_blk(logic [11:0] w);
    apb(1'b1, A_LO, {24'($urandom), w[7:0]}, 34'h0);
    apb(1'b1, A_HI, {28'($urandom), w[11:8]}, 34'h0);
    en_blk = w;
    apb(1'b0, A_LO, 32'h0, {2'b10, 24'h0, w[7:0]});
    apb(1'b0, A_HI, 32'h0, {2'b10, 28'h0, w[11:8]});
  endtask

  // ****************************************************************
  // Monitors: each result takes the oldest note.
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      ea = qa.pop_front();
      n_tests++;
      if (pslverr !== ea[32] || (ea[33] && prdata !== ea[31:0])) begin
        fails++;
        $display("BAD %0t apb %h err %b", $time, prdata, pslverr);
      end
    end
    if (io_dec.valid === 1'b1) begin
      ed = qd.pop_front();
      n_tests++;
      if (io_dec.forward !== ed[16] || io_dec.addr !== ed[15:0]) begin
        fails++;
        $display("BAD %0t port %h fwd %b", $time, io_dec.addr, io_dec.forward);
      end
    end
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("BAD %0t run did not finish", $time);
      conclude();
    end
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    void'($urandom(48347));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, A_LO, 32'h0, {2'b10, 32'h01});
    apb(1'b0, A_HI, 32'h0, {2'b10, 32'h0});
    apb(1'b0, A_IRQ, 32'h0, {2'b10, 32'h0});
    look(16'h0080, 1'b0);
    look(16'h0081, 1'b0);
    look(16'h0080, 1'b1);
    io_req <= '0;
    apb(1'b1, 12'h758, 32'hFF, {2'b01, 32'h0});
    apb(1'b0, 12'h75C, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 12'h751, 32'hFF, {2'b01, 32'h0});
    apb(1'b0, A_LO, 32'h0, {2'b10, 32'h01});
    $display("test reset and refusals done");
    // One block at a time, probing every block edge and its neighbours.
    for (int k = 0; k < 12; k++) begin
      io_req <= '0;
      set_blk(12'h001 << k);
      for (int j = 0; j < 12; j++) begin
        look(LO_T[j], 1'b0);
        look(HI_T[j], 1'b0);
        look(LO_T[j] - 16'h1, 1'b0);
        look(HI_T[j] + 16'h1, 1'b0);
      end
      look(LO_T[k], 1'b1);
    end
    $display("test block walk done");
    for (int r = 0; r < 20; r++) begin
      io_req <= '0;
      set_blk(12'($urandom));
      repeat (16) look(16'($urandom % 3072), 1'($urandom));
    end
    io_req <= '0;
    $display("test random lookups done");
    // Software writes the enables before cards drive the lines; the last pass clears all.
    for (int r = 0; r < 9; r++) begin
      en_irq = (r == 8) ? 8'h00 : ((r == 0) ? 8'hFF : 8'($urandom));
      apb(1'b1, A_IRQ, {24'($urandom), en_irq}, 34'h0);
      apb(1'b0, A_IRQ, 32'h0, {2'b10, 24'h0, en_irq});
      card_req <= (r == 8) ? 8'hFF : 8'($urandom);
      repeat (6) @(posedge ref_clk);
      n_tests++;
      if (serirq_irq !== (card_req & en_irq)) begin
        fails++;
        $display("BAD %0t irq %h", $time, serirq_irq);
      end
    end
    $display("test interrupts done");
    repeat (4) @(posedge ref_clk);
    conclude();
  end
endmodule
